// ---- core/display_window_geometry_regs.sv ----
// window geometry register bank with vertical-sync latching and region tracking
// assumes sync pulses and field flag arrive from outside the ref_clk domain
`default_nettype none

// Behaviour
// - line offset is a 9-bit burst count; fetch address steps that many bursts per line
// - one burst is 256 bits, so the count is width times depth over 256
// - four 32-bit source address registers hold absolute byte addresses of windows
// - five low address bits are ignored and always read back as zero
// - 10-bit horizontal base sets reference pixel counted from horizontal sync
// - 9-bit vertical base sets reference line counted from vertical sync
// - vertical base used is the larger of programmed value and one
// - video window 10-bit x start counts pixels from horizontal base
// - video window 0 9-bit y start counts lines from vertical base
// - video window 0 12-bit width gives displayed pixels
// - video window 0 11-bit height counts lines per field in frame mode
// - all geometry settings reach the working copy only at vertical sync
// - frame mode on interlaced output fetches alternate lines in each field
module display_window_geometry_regs
    import window_geometry_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic vertical_sync_pulse,
    input wire logic horizontal_sync_pulse,
    input wire logic odd_field,
    output logic [31:0] working_video0_source_address,
    output logic [31:0] working_video1_source_address,
    output logic [31:0] working_bitmap0_source_address,
    output logic [31:0] bitmap1_fetch_address,
    output logic video0_window_active,
    output logic video1_x_started
);

    // elaboration check: the map needs at least 6 address bits
    if (ADDR_WIDTH < 6 || ADDR_WIDTH > 32) begin : bad_addr_width
        $error("ADDR_WIDTH must lie between 6 and 32");
    end

    typedef struct packed {
        logic aw_taken;
        logic [7:0] aw_addr;
        logic w_taken;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        geometry_type programmed;
        geometry_type working;
        logic [2:0] vsync_pipe;
        logic [2:0] hsync_pipe;
        logic [2:0] field_pipe;
        logic vsync_level;
        logic hsync_level;
        logic field_level;
        logic field_is_odd;
        logic [pixel_count_width-1:0] pixel_count;
        logic [line_count_width-1:0] line_count;
        logic [address_keep_width-1:0] fetch_burst;
        logic video0_active;
        logic video1_started;
    } state_type;

    state_type state;
    state_type next_state;

    // merge write data into an old word under the byte strobes
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0] strobe);
        logic [31:0] merged;
        merged = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strobe[i]) begin
                merged[8*i +: 8] = new_word[8*i +: 8];
            end
        end
        return merged;
    endfunction

    // word index of a byte address, used by the write decode of the source address registers
    function automatic logic [3:0] reg_index(input logic [7:0] byte_addr);
        return byte_addr[5:2];
    endfunction

    // true when a byte address lands on a mapped register
    function automatic logic is_mapped(input logic [7:0] byte_addr);
        return (byte_addr[1:0] == 2'b00) && (byte_addr <= display_position_status_addr);
    endfunction

    // register read view; reserved bits come back zero
    function automatic logic [31:0] read_word(input state_type s, input logic [7:0] byte_addr);
        logic [31:0] word;
        word = 32'h0000_0000;
        unique case (byte_addr)
            bitmap_win1_line_offset_addr: word = 32'(s.programmed.bitmap1_line_burst_count);
            video_win0_source_address_addr:
                word = {s.programmed.source_address[0], address_drop_bits'(0)};
            video_win1_source_address_addr:
                word = {s.programmed.source_address[1], address_drop_bits'(0)};
            bitmap_win0_source_address_addr:
                word = {s.programmed.source_address[2], address_drop_bits'(0)};
            bitmap_win1_source_address_addr:
                word = {s.programmed.source_address[3], address_drop_bits'(0)};
            horizontal_base_reference_addr: word = 32'(s.programmed.horiz_base_pixels);
            vertical_base_reference_addr: word = 32'(s.programmed.vert_base_lines);
            video_win0_x_start_addr: word = 32'(s.programmed.video0_x_start_field);
            video_win0_y_start_addr: word = 32'(s.programmed.video0_y_start_field);
            video_win0_width_addr: word = 32'(s.programmed.video0_width_field);
            video_win0_height_addr: word = 32'(s.programmed.video0_height_field);
            video_win1_x_start_addr: word = 32'(s.programmed.video1_x_start_field);
            display_mode_control_addr: begin
                word[frame_mode_bit] = s.programmed.frame_mode;
                word[interlaced_bit] = s.programmed.interlaced;
            end
            display_position_status_addr: begin
                word[line_count_width-1:0] = s.line_count;
                word[status_field_bit] = s.field_is_odd;
            end
            default: word = 32'h0000_0000;
        endcase
        return word;
    endfunction

    // stored geometry updated by one bus write; fields keep their own widths
    function automatic geometry_type write_geometry(input geometry_type g,
                                                    input logic [7:0] byte_addr,
                                                    input logic [31:0] data,
                                                    input logic [3:0] strobe);
        geometry_type updated;
        logic [31:0] merged;
        logic [31:0] old_word;
        updated = g;
        old_word = 32'h0000_0000;
        merged = 32'h0000_0000;
        unique case (byte_addr)
            bitmap_win1_line_offset_addr: begin
                old_word = 32'(g.bitmap1_line_burst_count);
                merged = merge_bytes(old_word, data, strobe);
                updated.bitmap1_line_burst_count = merged[line_burst_width-1:0];
            end
            video_win0_source_address_addr, video_win1_source_address_addr,
            bitmap_win0_source_address_addr, bitmap_win1_source_address_addr: begin
                old_word = {g.source_address[2'(reg_index(byte_addr) - 4'd1)],
                            address_drop_bits'(0)};
                merged = merge_bytes(old_word, data, strobe);
                // low five bits never stored
                updated.source_address[2'(reg_index(byte_addr) - 4'd1)] =
                    merged[31:address_drop_bits];
            end
            horizontal_base_reference_addr: begin
                merged = merge_bytes(32'(g.horiz_base_pixels), data, strobe);
                updated.horiz_base_pixels = merged[horiz_pos_width-1:0];
            end
            vertical_base_reference_addr: begin
                merged = merge_bytes(32'(g.vert_base_lines), data, strobe);
                updated.vert_base_lines = merged[vert_pos_width-1:0];
            end
            video_win0_x_start_addr: begin
                merged = merge_bytes(32'(g.video0_x_start_field), data, strobe);
                updated.video0_x_start_field = merged[horiz_pos_width-1:0];
            end
            video_win0_y_start_addr: begin
                merged = merge_bytes(32'(g.video0_y_start_field), data, strobe);
                updated.video0_y_start_field = merged[vert_pos_width-1:0];
            end
            video_win0_width_addr: begin
                merged = merge_bytes(32'(g.video0_width_field), data, strobe);
                updated.video0_width_field = merged[width_field_width-1:0];
            end
            video_win0_height_addr: begin
                merged = merge_bytes(32'(g.video0_height_field), data, strobe);
                updated.video0_height_field = merged[height_field_width-1:0];
            end
            video_win1_x_start_addr: begin
                merged = merge_bytes(32'(g.video1_x_start_field), data, strobe);
                updated.video1_x_start_field = merged[horiz_pos_width-1:0];
            end
            display_mode_control_addr: begin
                old_word = 32'h0000_0000;
                old_word[frame_mode_bit] = g.frame_mode;
                old_word[interlaced_bit] = g.interlaced;
                merged = merge_bytes(old_word, data, strobe);
                updated.frame_mode = merged[frame_mode_bit];
                updated.interlaced = merged[interlaced_bit];
            end
            default: updated = g;
        endcase
        return updated;
    endfunction

    // intermediate terms of the next-state logic
    logic vsync_edge;
    logic hsync_edge;
    logic [vert_pos_width-1:0] vert_base_used;
    logic [pixel_count_width-1:0] h_open;
    logic [pixel_count_width-1:0] h_close;
    logic [pixel_count_width-1:0] h1_open;
    logic [line_count_width-1:0] v_open;
    logic [line_count_width-1:0] v_close;
    logic alternate_lines;
    logic [address_keep_width-1:0] line_step;

    // whole next state in one process
    always_comb begin
        next_state = state;

        // sync inputs: three flops, a change counts when stages two and three agree
        next_state.vsync_pipe = {state.vsync_pipe[1:0], vertical_sync_pulse};
        next_state.hsync_pipe = {state.hsync_pipe[1:0], horizontal_sync_pulse};
        next_state.field_pipe = {state.field_pipe[1:0], odd_field};
        if (state.vsync_pipe[1] == state.vsync_pipe[2]) begin
            next_state.vsync_level = state.vsync_pipe[2];
        end
        if (state.hsync_pipe[1] == state.hsync_pipe[2]) begin
            next_state.hsync_level = state.hsync_pipe[2];
        end
        if (state.field_pipe[1] == state.field_pipe[2]) begin
            next_state.field_level = state.field_pipe[2];
        end
        vsync_edge = (state.vsync_pipe[1] == state.vsync_pipe[2]) && state.vsync_pipe[2]
                     && !state.vsync_level;
        hsync_edge = (state.hsync_pipe[1] == state.hsync_pipe[2]) && state.hsync_pipe[2]
                     && !state.hsync_level;

        // region bounds from the working copy; zero base treated as one
        vert_base_used = (state.working.vert_base_lines == '0) ? vert_base_floor
                         : state.working.vert_base_lines;
        h_open = pixel_count_width'(state.working.horiz_base_pixels)
                 + pixel_count_width'(state.working.video0_x_start_field);
        h_close = h_open + pixel_count_width'(state.working.video0_width_field);
        h1_open = pixel_count_width'(state.working.horiz_base_pixels)
                  + pixel_count_width'(state.working.video1_x_start_field);
        v_open = line_count_width'(vert_base_used)
                 + line_count_width'(state.working.video0_y_start_field);
        // height counts lines per field, matching the per-field line counter
        v_close = v_open + line_count_width'(state.working.video0_height_field);

        // running counters; saturate rather than wrap on a missing sync
        if (hsync_edge) begin
            next_state.pixel_count = '0;
        end else if (state.pixel_count != '1) begin
            next_state.pixel_count = state.pixel_count + pixel_count_width'(1);
        end
        if (vsync_edge) begin
            next_state.line_count = '0;
        end else if (hsync_edge && state.line_count != '1) begin
            next_state.line_count = state.line_count + line_count_width'(1);
        end

        // region flags, one cycle behind the counters
        next_state.video0_active = (state.pixel_count >= h_open) && (state.pixel_count < h_close)
                                   && (state.line_count >= v_open)
                                   && (state.line_count < v_close);
        next_state.video1_started = state.pixel_count >= h1_open;

        // bitmap 1 fetch: one burst is 256 bits, so bursts step the address in 32-byte units
        alternate_lines = state.working.frame_mode && state.working.interlaced;
        line_step = alternate_lines
                    ? address_keep_width'({state.working.bitmap1_line_burst_count, 1'b0})
                    : address_keep_width'(state.working.bitmap1_line_burst_count);
        if (vsync_edge) begin
            // field flag and mode as they stand at this edge, not one cycle stale
            next_state.field_is_odd = next_state.field_level;
            // odd field of a stored frame starts one line in
            next_state.fetch_burst = state.programmed.source_address[3]
                + ((state.programmed.frame_mode && state.programmed.interlaced
                    && next_state.field_level)
                   ? address_keep_width'(state.programmed.bitmap1_line_burst_count)
                   : address_keep_width'(0));
        end else if (hsync_edge && state.line_count >= line_count_width'(vert_base_used)) begin
            next_state.fetch_burst = state.fetch_burst + line_step;
        end

        // settings reach the display side only on the vertical sync edge
        if (vsync_edge) begin
            next_state.working = state.programmed;
        end

        // write channel: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_state.aw_taken = 1'b1;
            next_state.aw_addr = 8'(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_state.w_taken = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (state.aw_taken && state.w_taken) begin
            next_state.aw_taken = 1'b0;
            next_state.w_taken = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = is_mapped(state.aw_addr) ? resp_okay : resp_slverr;
            // writes to the status word are ignored
            if (is_mapped(state.aw_addr)) begin
                next_state.programmed = write_geometry(state.programmed, state.aw_addr,
                                                       state.w_data, state.w_strb);
            end
        end

        // read channel: one cycle from acceptance to data
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_state.rvalid = 1'b1;
            next_state.rdata = is_mapped(8'(s_axi_araddr))
                               ? read_word(state, 8'(s_axi_araddr)) : 32'h0000_0000;
            next_state.rresp = is_mapped(8'(s_axi_araddr)) ? resp_okay : resp_slverr;
        end
    end

    // single state register; reset clears everything to zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // handshake outputs; a new request waits until the previous answer drains
    assign s_axi_awready = !state.aw_taken && !state.bvalid;
    assign s_axi_wready = !state.w_taken && !state.bvalid;
    assign s_axi_arready = !state.rvalid;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;

    // working copies seen by the fetch and mixer side
    assign working_video0_source_address = {state.working.source_address[0],
                                            address_drop_bits'(0)};
    assign working_video1_source_address = {state.working.source_address[1],
                                            address_drop_bits'(0)};
    assign working_bitmap0_source_address = {state.working.source_address[2],
                                             address_drop_bits'(0)};
    assign bitmap1_fetch_address = {state.fetch_burst, address_drop_bits'(0)};
    assign video0_window_active = state.video0_active;
    assign video1_x_started = state.video1_started;

endmodule
`default_nettype wire

// ---- core/window_geometry_pkg.sv ----
// constants for the window geometry register bank: offsets, fields, resets
// assumes a 32-bit AXI4-Lite register bus and a 100 MHz ref_clk
`default_nettype none
package window_geometry_pkg;
    // register byte offsets, one aligned word each
    localparam logic [7:0] bitmap_win1_line_offset_addr = 8'h00;
    localparam logic [7:0] video_win0_source_address_addr = 8'h04;
    localparam logic [7:0] video_win1_source_address_addr = 8'h08;
    localparam logic [7:0] bitmap_win0_source_address_addr = 8'h0C;
    localparam logic [7:0] bitmap_win1_source_address_addr = 8'h10;
    localparam logic [7:0] horizontal_base_reference_addr = 8'h14;
    localparam logic [7:0] vertical_base_reference_addr = 8'h18;
    localparam logic [7:0] video_win0_x_start_addr = 8'h1C;
    localparam logic [7:0] video_win0_y_start_addr = 8'h20;
    localparam logic [7:0] video_win0_width_addr = 8'h24;
    localparam logic [7:0] video_win0_height_addr = 8'h28;
    localparam logic [7:0] video_win1_x_start_addr = 8'h2C;
    localparam logic [7:0] display_mode_control_addr = 8'h30;
    localparam logic [7:0] display_position_status_addr = 8'h34;

    // field widths
    localparam int line_burst_width = 9;
    localparam int address_drop_bits = 5;
    localparam int address_keep_width = 32 - address_drop_bits;
    localparam int horiz_pos_width = 10;
    localparam int vert_pos_width = 9;
    localparam int width_field_width = 12;
    localparam int height_field_width = 11;
    localparam int pixel_count_width = 13;
    localparam int line_count_width = 12;

    // control and status field positions
    localparam int frame_mode_bit = 0;
    localparam int interlaced_bit = 1;
    localparam int status_field_bit = 16;

    // reset values
    localparam logic [31:0] geometry_reset_value = 32'h0000_0000;
    localparam logic [vert_pos_width-1:0] vert_base_floor = 9'h001;

    // AXI response codes
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    // programmed and working copies share one layout
    typedef struct packed {
        logic [line_burst_width-1:0] bitmap1_line_burst_count;
        logic [3:0][address_keep_width-1:0] source_address;
        logic [horiz_pos_width-1:0] horiz_base_pixels;
        logic [vert_pos_width-1:0] vert_base_lines;
        logic [horiz_pos_width-1:0] video0_x_start_field;
        logic [vert_pos_width-1:0] video0_y_start_field;
        logic [width_field_width-1:0] video0_width_field;
        logic [height_field_width-1:0] video0_height_field;
        logic [horiz_pos_width-1:0] video1_x_start_field;
        logic frame_mode;
        logic interlaced;
    } geometry_type;
endpackage
`default_nettype wire

// ---- verif/display_window_geometry_props.sv ----
// bus handshake and latching checks for the window geometry bank
// assumes sync pins stay high at least three ref_clk cycles per pulse
`default_nettype none
module display_window_geometry_props #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic vertical_sync_pulse,
    input wire logic [31:0] working_video0_source_address,
    input wire logic [31:0] bitmap1_fetch_address
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> ##1 s_axi_bvalid) else $error("write not answered");
    a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
        $stable(s_axi_bresp)) else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_latch_vsync: assert property ($changed(working_video0_source_address) |->
        $past(vertical_sync_pulse, 3)) else $error("working copy moved without vsync");
    a_addr_low: assert property (working_video0_source_address[4:0] == 5'h00)
        else $error("working address low bits set");
    a_fetch_low: assert property (bitmap1_fetch_address[4:0] == 5'h00)
        else $error("fetch address off burst boundary");
endmodule
bind display_window_geometry_regs display_window_geometry_props #(
    .ADDR_WIDTH(ADDR_WIDTH)) i_props (.*);
`default_nettype wire

// ---- verif/display_window_geometry_regs_tb_top.sv ----
// self-checking bench for the window geometry bank over AXI4-Lite
// assumes the checker binds itself; sync pins are driven by the bench
`default_nettype none
module display_window_geometry_regs_tb_top import window_geometry_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, vertical_sync_pulse = 0, odd_field = 0;
    logic horizontal_sync_pulse = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, video0_window_active, video1_x_started;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, working_video0_source_address, d, f0;
    logic [31:0] working_video1_source_address, working_bitmap0_source_address;
    logic [31:0] bitmap1_fetch_address, mdl [12];
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int n_fail = 0, tests_run = 0, t0, t1, hb;
    // writable bits per word; reserved bits must stay zero
    localparam logic [31:0] mask [12] = '{32'h0000_01ff, 32'hffff_ffe0, 32'hffff_ffe0,
        32'hffff_ffe0, 32'hffff_ffe0, 32'h0000_03ff, 32'h0000_01ff, 32'h0000_03ff,
        32'h0000_01ff, 32'h0000_0fff, 32'h0000_07ff, 32'h0000_03ff};
    display_window_geometry_regs i_dut (.*);
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 0;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            // ready comes a cycle late so a held response gets exercised
            if (s_axi_bvalid === 1'b1 && !s_axi_bready) s_axi_bready <= 1;
        end while (!(s_axi_bvalid === 1'b1 && s_axi_bready));
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 0;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (!s_axi_arvalid && !s_axi_rready) s_axi_rready <= 1;
        end while (!(s_axi_rvalid === 1'b1 && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    // pulse long enough for the three-flop synchroniser on both edges
    task automatic pulse(input bit v);
        if (v) vertical_sync_pulse <= 1;
        else horizontal_sync_pulse <= 1;
        repeat (4) @(posedge ref_clk);
        vertical_sync_pulse <= 0;
        horizontal_sync_pulse <= 0;
        repeat (6) @(posedge ref_clk);
    endtask
    // cycles from a line start until the video 1 start point is passed
    task automatic span(output int c);
        pulse(0);
        c = 0;
        while (video1_x_started !== 1'b1) begin
            @(posedge ref_clk);
            c++;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #200us;
        n_fail++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h5bae));
        repeat (20) @(posedge ref_clk);
        rst_n <= 1;
        @(posedge ref_clk);
        for (int i = 0; i < 12; i++) begin
            rd(8'(i * 4));
            chk(d, 32'h0000_0000);
            d = $urandom();
            mdl[i] = d & mask[i];
            wr(8'(i * 4), d);
            chk(32'(r), 32'(resp_okay));
            rd(8'(i * 4));
            chk(d, mdl[i]);
        end
        wr(8'h40, 32'hffff_ffff);
        chk(32'(r), 32'(resp_slverr));
        rd(8'h40);
        chk(d, 32'h0000_0000);
        $display("register test done");
        chk(working_video0_source_address, 32'h0000_0000);
        pulse(1);
        chk(working_video0_source_address, mdl[1]);
        chk(working_video1_source_address, mdl[2]);
        chk(working_bitmap0_source_address, mdl[3]);
        $display("latch test done");
        // normal mode steps one line, interlaced frame mode two
        for (int m = 0; m < 4; m += 3) begin
            wr(8'h30, 32'(m));
            wr(8'h18, 32'h0000_0000);
            odd_field <= m[0];
            pulse(1);
            chk(bitmap1_fetch_address, mdl[4] + (m[0] ? mdl[0] * 32 : 0));
            repeat (2) pulse(0);
            f0 = bitmap1_fetch_address;
            pulse(0);
            chk(bitmap1_fetch_address - f0, mdl[0] * 32 * (m[0] ? 2 : 1));
        end
        $display("fetch test done");
        hb = 24 + $urandom() % 400;
        wr(8'h14, 32'(hb));
        wr(8'h2C, 32'h0000_0008);
        pulse(1);
        span(t0);
        wr(8'h2C, 32'h0000_0013);
        pulse(1);
        span(t1);
        chk(32'(t1 - t0), 32'h0000_000b);
        wr(8'h14, 32'(hb + 16));
        pulse(1);
        span(t0);
        chk(32'(t0 - t1), 32'h0000_0010);
        // video 0 one line tall; zero base means it opens at line one
        wr(8'h1C, 32'h0000_0000);
        wr(8'h20, 32'h0000_0000);
        wr(8'h24, 32'h0000_0fff);
        wr(8'h28, 32'h0000_0001);
        pulse(1);
        chk(32'(video0_window_active), 32'h0000_0000);
        pulse(0);
        chk(32'(video0_window_active), 32'h0000_0000);
        repeat (hb + 16) @(posedge ref_clk);
        chk(32'(video0_window_active), 32'h0000_0001);
        pulse(0);
        repeat (hb + 16) @(posedge ref_clk);
        chk(32'(video0_window_active), 32'h0000_0000);
        rd(8'h34);
        chk(d, 32'h0001_0002);
        $display("region test done");
        stop_test();
    end
endmodule
`default_nettype wire
